// ### hw/adc_ctrl_pkg.sv
// package for the converter control block: register map, fields, codes, timing
// assumes an apb master with 32-bit data and a 50 MHz system clock
package adc_ctrl_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_CONTROL_ONE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_SAMPLE_TIME = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_RESULT_BASE = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h044;
  localparam int unsigned BUF_DEPTH = 4;
  localparam int unsigned BUF_AW = 2;
  localparam int unsigned DATA_BITS = 10;
  // control one bit positions
  localparam int unsigned BIT_ON = 15;
  localparam int unsigned BIT_IDLE = 13;
  localparam int unsigned BIT_FORM_LO = 8;
  localparam int unsigned BIT_SRC_LO = 5;
  localparam int unsigned BIT_AUTO_SAMPLE = 2;
  localparam int unsigned BIT_SAMPLE_ENABLE = 1;
  localparam int unsigned BIT_DONE = 0;
  localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
  // result formats
  localparam logic [1:0] FORM_INT = 2'h0;
  localparam logic [1:0] FORM_SINT = 2'h1;
  localparam logic [1:0] FORM_FRAC = 2'h2;
  localparam logic [1:0] FORM_SFRAC = 2'h3;
  // trigger sources
  localparam logic [2:0] SRC_MANUAL = 3'h0;
  localparam logic [2:0] SRC_EXT_PIN = 3'h1;
  localparam logic [2:0] SRC_TIMER3 = 3'h2;
  localparam logic [2:0] SRC_TIMER5 = 3'h4;
  localparam logic [2:0] SRC_CHARGE = 3'h6;
  localparam logic [2:0] SRC_AUTO = 3'h7;
  // irq status bits
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_LOST = 1;
  localparam int unsigned IRQ_BITS = 2;
  // conversion time: 12 bit periods of 1 us each
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CONV_TIME_NS = 12_000;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] SAMPLE_TIME_RESET = 8'h10;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_IDLE = 2'b01,
    ST_SAMPLE = 2'b11,
    ST_CONVERT = 2'b10
  } conv_state_e;
  typedef struct packed {
    logic charge;
    logic timer5;
    logic timer3;
    logic ext_pin;
  } trigger_s;
endpackage

// ### hw/adc_result_mem.sv
// small result memory, registered read data
// assumes single clock, one write and one read port
`timescale 1ns/1ns
module adc_result_mem
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = BUF_DEPTH,
  parameter int unsigned AW = BUF_AW
)
(
  // clock
  input wire logic clk_sys_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  // no reset on the array: contents are invalidated by the valid bits upstream
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
  end
endmodule

// ### hw/adc_conversion_control.sv
// converter control block: control register one, sequencing, results, irq
// assumes apb master, raw sample from the analog front end on adc_sample_i
`timescale 1ns/1ns
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // trigger events, one-cycle pulses
  input wire trigger_s trig_i,
  // analog front end
  input wire logic [DATA_BITS-1:0] adc_sample_i,
  input wire logic idle_mode_i,
  output logic track_o,
  output logic convert_o,
  // interrupt
  output logic irq_o
);
  // decode of the control fields, used by register logic and sequencer
  function automatic logic is_reserved_src(input logic [2:0] s);
    return (s == 3'h5) || (s == 3'h3);
  endfunction

  function automatic logic [15:0] format_result(input logic [1:0] f,
                                                input logic [DATA_BITS-1:0] d);
    logic [15:0] r;
    r = 16'h0000;
    unique case (f)
      FORM_INT: r = {{(16-DATA_BITS){1'b0}}, d};
      FORM_SINT: r = {{(16-DATA_BITS+1){~d[DATA_BITS-1]}}, d[DATA_BITS-2:0]};
      FORM_FRAC: r = {d, {(16-DATA_BITS){1'b0}}};
      FORM_SFRAC: r = {~d[DATA_BITS-1], d[DATA_BITS-2:0], {(16-DATA_BITS){1'b0}}};
    endcase
    return r;
  endfunction

  // control one fields and the sample time
  logic on_r, on_nxt;
  logic idle_stop_r, idle_stop_nxt;
  logic [1:0] form_r, form_nxt;
  logic [2:0] src_r, src_nxt;
  logic auto_sample_r, auto_sample_nxt;
  logic sample_enable_r, sample_enable_nxt;
  logic done_r, done_nxt;
  logic [7:0] sample_enable_time_r, sample_enable_time_nxt;
  // sequencer
  conv_state_e state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [BUF_AW-1:0] wptr_r, wptr_nxt;
  logic [BUF_DEPTH-1:0] valid_r, valid_nxt;
  // irq
  logic [IRQ_BITS-1:0] irq_stat_r, irq_stat_nxt;
  logic [IRQ_BITS-1:0] irq_mask_r, irq_mask_nxt;
  // bus and pin outputs
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic track_nxt, convert_nxt, irq_nxt;

  logic acc, wr, rd, low_lanes;
  logic run, conv_end, trig_hit, mem_wr, res_read;
  logic [15:0] ctl_word;
  logic [BUF_AW-1:0] rd_idx;
  logic [15:0] mem_rd;
  logic [15:0] res_word;

  // setup cycle reads nothing; access phase answers after one wait state
  assign acc = psel_i && penable_i && !pready_o;
  assign wr = acc && pwrite_i;
  assign rd = acc && !pwrite_i;
  assign low_lanes = pstrb_i[0] && pstrb_i[1];
  assign rd_idx = paddr_i[BUF_AW+1:2];
  assign res_read = (paddr_i >= OFF_RESULT_BASE) &&
                    (paddr_i < OFF_RESULT_BASE + ADDR_W'(4 * BUF_DEPTH));
  assign ctl_word = {on_r, 1'b0, idle_stop_r, 3'h0, form_r, src_r, 2'h0,
                     auto_sample_r, sample_enable_r, done_r};
  // idle stop aborts the converter while the system idles
  assign run = on_r && !(idle_stop_r && idle_mode_i);
  assign conv_end = (state_r == ST_CONVERT) && (cnt_r == 16'h0001);
  assign mem_wr = run && conv_end;
  assign res_word = format_result(form_r, adc_sample_i);

  // which trigger closes the sample window
  always_comb
  begin
    trig_hit = 1'b0;
    unique case (src_r)
      SRC_EXT_PIN: trig_hit = trig_i.ext_pin;
      SRC_TIMER3: trig_hit = trig_i.timer3;
      SRC_TIMER5: trig_hit = trig_i.timer5;
      SRC_CHARGE: trig_hit = trig_i.charge;
      SRC_AUTO: trig_hit = (cnt_r == 16'h0001);
      default: trig_hit = 1'b0; // manual and reserved: software clears sample_enable
    endcase
  end

  // register and sequencer next state
  always_comb
  begin
    on_nxt = on_r;
    idle_stop_nxt = idle_stop_r;
    form_nxt = form_r;
    src_nxt = src_r;
    auto_sample_nxt = auto_sample_r;
    sample_enable_nxt = sample_enable_r;
    done_nxt = done_r;
    sample_enable_time_nxt = sample_enable_time_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    wptr_nxt = wptr_r;
    valid_nxt = valid_r;
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    // software writes first, hardware events below win over them
    if (wr && low_lanes)
    begin
      unique case (paddr_i)
        OFF_CONTROL_ONE:
        begin
          on_nxt = pwdata_i[BIT_ON];
          idle_stop_nxt = pwdata_i[BIT_IDLE];
          form_nxt = pwdata_i[BIT_FORM_LO +: 2];
          // a reserved code keeps the previous source
          if (!is_reserved_src(pwdata_i[BIT_SRC_LO +: 3]))
          begin
            src_nxt = pwdata_i[BIT_SRC_LO +: 3];
          end
          auto_sample_nxt = pwdata_i[BIT_AUTO_SAMPLE];
          sample_enable_nxt = pwdata_i[BIT_SAMPLE_ENABLE];
          if (!pwdata_i[BIT_DONE])
          begin
            done_nxt = 1'b0;
          end
        end
        OFF_SAMPLE_TIME: sample_enable_time_nxt = pwdata_i[7:0];
        OFF_IRQ_STATUS: irq_stat_nxt = irq_stat_r & ~pwdata_i[IRQ_BITS-1:0];
        OFF_IRQ_MASK: irq_mask_nxt = pwdata_i[IRQ_BITS-1:0];
        default: ;
      endcase
    end
    unique case (state_r)
      ST_OFF:
      begin
        if (run)
        begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (sample_enable_nxt)
        begin
          state_nxt = ST_SAMPLE;
          cnt_nxt = {8'h00, sample_enable_time_r};
        end
      end
      ST_SAMPLE:
      begin
        if (cnt_r != 16'h0000)
        begin
          cnt_nxt = cnt_r - 16'h0001;
        end
        // sampling ends on the trigger, or on software clearing sample_enable
        if (trig_hit || !sample_enable_nxt)
        begin
          sample_enable_nxt = 1'b0;
          done_nxt = 1'b0;
          state_nxt = ST_CONVERT;
          cnt_nxt = 16'(CONV_CYCLES);
        end
      end
      ST_CONVERT:
      begin
        cnt_nxt = cnt_r - 16'h0001;
        if (conv_end)
        begin
          done_nxt = 1'b1;
          irq_stat_nxt[IRQ_DONE] = 1'b1;
          if (valid_r[wptr_r])
          begin
            irq_stat_nxt[IRQ_LOST] = 1'b1;
          end
          valid_nxt[wptr_r] = 1'b1;
          wptr_nxt = wptr_r + BUF_AW'(1);
          state_nxt = ST_IDLE;
          if (auto_sample_r)
          begin
            sample_enable_nxt = 1'b1;
            state_nxt = ST_SAMPLE;
            cnt_nxt = {8'h00, sample_enable_time_r};
          end
        end
      end
    endcase
    // reading a result frees its slot; a result landing there in the same cycle wins
    if (rd && res_read && !(mem_wr && (rd_idx == wptr_r)))
    begin
      valid_nxt[rd_idx] = 1'b0;
    end
    // off or idle-stopped: abort and drop every stored result
    if (!run)
    begin
      state_nxt = ST_OFF;
      sample_enable_nxt = sample_enable_nxt && on_nxt;
      valid_nxt = '0;
      wptr_nxt = '0;
    end
  end

  // bus answer and pin outputs
  always_comb
  begin
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (acc)
    begin
      if (res_read)
      begin
        prdata_nxt = {16'h0000, mem_rd};
      end
      else
      begin
        unique case (paddr_i)
          OFF_CONTROL_ONE: prdata_nxt = {16'h0000, ctl_word};
          OFF_SAMPLE_TIME: prdata_nxt = {24'h000000, sample_enable_time_r};
          OFF_IRQ_STATUS: prdata_nxt = {30'h0, irq_stat_r};
          OFF_IRQ_MASK: prdata_nxt = {30'h0, irq_mask_r};
          default: pslverr_nxt = 1'b1;
        endcase
      end
    end
    track_nxt = (state_nxt == ST_SAMPLE);
    convert_nxt = (state_nxt == ST_CONVERT);
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  // registers only
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      on_r <= CONTROL_ONE_RESET[BIT_ON];
      idle_stop_r <= CONTROL_ONE_RESET[BIT_IDLE];
      form_r <= CONTROL_ONE_RESET[BIT_FORM_LO +: 2];
      src_r <= CONTROL_ONE_RESET[BIT_SRC_LO +: 3];
      auto_sample_r <= CONTROL_ONE_RESET[BIT_AUTO_SAMPLE];
      sample_enable_r <= CONTROL_ONE_RESET[BIT_SAMPLE_ENABLE];
      done_r <= CONTROL_ONE_RESET[BIT_DONE];
      sample_enable_time_r <= SAMPLE_TIME_RESET;
      state_r <= ST_OFF;
      cnt_r <= 16'h0000;
      wptr_r <= '0;
      valid_r <= '0;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      track_o <= 1'b0;
      convert_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      on_r <= on_nxt;
      idle_stop_r <= idle_stop_nxt;
      form_r <= form_nxt;
      src_r <= src_nxt;
      auto_sample_r <= auto_sample_nxt;
      sample_enable_r <= sample_enable_nxt;
      done_r <= done_nxt;
      sample_enable_time_r <= sample_enable_time_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wptr_r <= wptr_nxt;
      valid_r <= valid_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      prdata_o <= prdata_nxt;
      pready_o <= pready_nxt;
      pslverr_o <= pslverr_nxt;
      track_o <= track_nxt;
      convert_o <= convert_nxt;
      irq_o <= irq_nxt;
    end
  end

  // result slots; read data registered, so bus reads use the previous cycle's address
  adc_result_mem #(
    .WIDTH(16),
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_result_mem (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(mem_wr),
    .wr_addr_i(wptr_r),
    .wr_data_i(res_word),
    .rd_addr_i(rd_idx),
    .rd_data_o(mem_rd)
  );
endmodule

// ### verification/adc_ctrl_sva.sv
// checker for the converter control block: bus timing and conversion sequencing
// assumes binding to adc_conversion_control, sees its ports only
`timescale 1ns/1ns
module adc_ctrl_sva
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  // converter side
  input wire trigger_s trig_i,
  input wire logic track_o,
  input wire logic convert_o
);
  logic [9:0] cnt_r, cnt_nxt;
  logic [2:0] src_r, src_nxt;
  logic on_r, on_nxt, auto_sample_r, auto_sample_nxt, ctl_wr, hit;
  // shadow of committed control writes; reserved sources never land
  always_comb
  begin
    ctl_wr = psel_i && penable_i && pready_o && pwrite_i;
    ctl_wr = ctl_wr && paddr_i == OFF_CONTROL_ONE && pstrb_i[1:0] == 2'h3;
    on_nxt = ctl_wr ? pwdata_i[BIT_ON] : on_r;
    auto_sample_nxt = ctl_wr ? pwdata_i[BIT_AUTO_SAMPLE] : auto_sample_r;
    src_nxt = src_r;
    if (ctl_wr && !(pwdata_i[7:5] inside {3'h3, 3'h5}))
      src_nxt = pwdata_i[7:5];
    cnt_nxt = convert_o ? cnt_r + 10'h1 : 10'h0;
    hit = src_r == SRC_CHARGE && trig_i.charge || src_r == SRC_TIMER5 && trig_i.timer5;
    hit = track_o && (hit || src_r == SRC_TIMER3 && trig_i.timer3
      || src_r == SRC_EXT_PIN && trig_i.ext_pin);
  end
  // registers only
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_r <= 10'h0;
      src_r <= 3'h0;
      on_r <= 1'b0;
      auto_sample_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      src_r <= src_nxt;
      on_r <= on_nxt;
      auto_sample_r <= auto_sample_nxt;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence conv_end;
    $fell(convert_o) && on_r;
  endsequence
  off_quiet_a: assert property (!on_r && !$past(on_r) |-> !track_o && !convert_o)
    else $error("converter active while off");
  conv_len_a: assert property (conv_end |-> cnt_r == CONV_CYCLES)
    else $error("conversion length wrong");
  track_excl_a: assert property (!(track_o && convert_o))
    else $error("tracking during conversion");
  trig_start_a: assert property (hit |=> convert_o && !track_o)
    else $error("trigger did not start conversion");
  auto_restart_a: assert property (conv_end ##0 auto_sample_r |-> ##[1:2] track_o)
    else $error("auto sampling did not restart");
  sample_end_a: assert property ($fell(track_o) && on_r |-> convert_o)
    else $error("sampling ended without conversion");
  ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("bus answer late");
endmodule
bind adc_conversion_control adc_ctrl_sva sva (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o), .trig_i(trig_i),
  .track_o(track_o), .convert_o(convert_o));

// ### verification/adc_conversion_control_tb_top.sv
// self-checking bench for the converter control block
// assumes the package, design and bound checker compile first
`timescale 1ns/1ns
module adc_conversion_control_tb_top;
  import adc_ctrl_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, track, conv, irq, perr;
  trigger_s trig = 4'h0;
  logic [DATA_BITS-1:0] smp = 10'h0;
  logic [31:0] seed = 32'hac6c;
  int err_count = 0;
  int comparisons = 0;
  // 50 MHz
  always #10 clk_sys_i = ~clk_sys_i;
  adc_conversion_control dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .trig_i(trig),
    .adc_sample_i(smp), .idle_mode_i(1'b0), .track_o(track), .convert_o(conv), .irq_o(irq));
  // model of the result layout per format code
  function automatic logic [31:0] fmt(input logic [9:0] d, input int f);
    case (f)
      1: return {16'h0, {7{~d[9]}}, d[8:0]}; // mid-scale is zero, top bit inverts
      2: return {16'h0, d, 6'h0};
      3: return {16'h0, ~d[9], d[8:0], 6'h0};
      default: return {22'h0, d};
    endcase
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // one transfer; idle edge first so back to back calls never clash
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung transfer
    do @(negedge clk_sys_i); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    @(posedge clk_sys_i);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_irq();
    do @(negedge clk_sys_i); while (irq !== 1'b1);
    @(posedge clk_sys_i);
  endtask
  task automatic end_sim();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog, far beyond the seven conversions
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    end_sim();
  end
  // main sequence
  initial
  begin
    logic [2:0] src [5];
    logic [3:0] tb [5];
    logic [15:0] cw;
    int f;
    src = '{SRC_MANUAL, SRC_EXT_PIN, SRC_TIMER3, SRC_TIMER5, SRC_CHARGE};
    tb = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    repeat (5) @(posedge clk_sys_i);
    reset_n <= 1'b1;
    apb(1'b0, OFF_CONTROL_ONE, 32'h0);
    chk(32'h0, rd);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(32'h1, {31'h0, perr});
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    // every source except auto, every format, results round robin
    for (int i = 0; i < 5; i++)
    begin
      // inputs change on the rising edge only
      @(posedge clk_sys_i);
      seed = xs(seed);
      smp <= seed[9:0];
      f = i % 4;
      cw = 16'h8002 | (16'(f) << 8) | (16'(src[i]) << 5);
      apb(1'b1, OFF_CONTROL_ONE, {16'h0, cw});
      if (i == 0)
        apb(1'b1, OFF_CONTROL_ONE, {16'h0, cw & 16'hfffd});
      else
      begin
        @(posedge clk_sys_i);
        trig <= tb[i];
        @(posedge clk_sys_i);
        trig <= 4'h0;
      end
      wait_irq();
      apb(1'b0, OFF_CONTROL_ONE, 32'h0);
      chk({16'h0, cw & 16'hfffd | 16'h1}, rd);
      apb(1'b0, OFF_RESULT_BASE + 12'(4 * (i % 4)), 32'h0);
      chk(fmt(smp, f), rd);
      apb(1'b1, OFF_IRQ_STATUS, 32'h1);
      repeat (2) @(negedge clk_sys_i);
      chk(32'h0, {31'h0, irq});
    end
    apb(1'b1, OFF_CONTROL_ONE, 32'h80a0);
    apb(1'b0, OFF_CONTROL_ONE, 32'h0);
    chk(32'h80c0, rd);
    pstrb <= 4'hc;
    apb(1'b1, OFF_CONTROL_ONE, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, OFF_CONTROL_ONE, 32'h0);
    chk(32'h80c0, rd);
    // timed source: sampling closes itself after the programmed sample time
    apb(1'b1, OFF_SAMPLE_TIME, 32'h4);
    apb(1'b0, OFF_SAMPLE_TIME, 32'h0);
    chk(32'h4, rd);
    seed = xs(seed);
    smp <= seed[9:0];
    apb(1'b1, OFF_CONTROL_ONE, 32'h80e2);
    wait_irq();
    apb(1'b0, OFF_CONTROL_ONE, 32'h0);
    chk(32'h80e1, rd);
    apb(1'b0, OFF_RESULT_BASE + 12'h4, 32'h0);
    chk(fmt(smp, 0), rd);
    apb(1'b1, OFF_IRQ_STATUS, 32'h1);
    // auto sampling with the interrupt masked, then unmasked
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    apb(1'b1, OFF_CONTROL_ONE, 32'h8026);
    @(posedge clk_sys_i);
    trig <= 4'h1;
    @(posedge clk_sys_i);
    trig <= 4'h0;
    // the trigger must have closed the first sample window
    @(negedge clk_sys_i);
    chk(32'h1, {31'h0, conv});
    repeat (CONV_CYCLES + 4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(32'h1, {31'h0, track});
    chk(32'h0, {31'h0, irq});
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk_sys_i);
    chk(32'h1, {31'h0, irq});
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    chk(32'h1, rd);
    apb(1'b1, OFF_CONTROL_ONE, 32'h0);
    repeat (2) @(negedge clk_sys_i);
    chk(32'h0, {30'h0, track, conv});
    end_sim();
  end
endmodule
